//--- hw/sdtx_pkg.sv
package sdtx_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_DRIVE    = 8'h20;
  localparam logic [7:0] IDX_LINKTEST = 8'h22;
  localparam logic [7:0] IDX_ERRCNT   = 8'h2e;
  localparam logic [7:0] IDX_FORCE1   = 8'h3c;
  localparam logic [7:0] IDX_BLKSEL   = 8'h3e;

  // block numbers behind the shared index
  localparam logic [3:0] BLK_CTRL1 = 4'h0;
  localparam logic [3:0] BLK_DRIVE = 4'h1;

  // field positions
  localparam int CTL1_OVR_BIT   = 12;
  localparam int CTL1_FIBER_BIT = 0;
  localparam int DRV_AMP_LSB    = 12;
  localparam int DRV_RSV_LSB    = 9;
  localparam int DRV_EMPH_LSB   = 6;
  localparam int LT_CLR_BIT     = 14;
  localparam int LT_IDLE_BIT    = 13;
  localparam int LT_FORCE_BIT   = 5;
  localparam int ERR_BER_LSB    = 8;
  localparam int AMP_MODE_BIT   = 2;

  // reset values
  localparam logic [3:0] DRV_AMP_RST     = 4'hc;
  localparam logic [2:0] DRV_RSV_MID     = 3'h4;
  localparam logic [2:0] DRV_EMPH_RST    = 3'h0;
  localparam logic [5:0] DRV_RSV_LOW_RST = 6'h20;
  localparam logic [9:0] FORCE1_RST      = 10'h289;
  localparam logic [3:0] BLK_SEL_RST     = 4'h0;

  // idle test pattern
  typedef logic [9:0] sdtx_code_t;
  localparam int         IDLE_STAGES      = 16;
  localparam logic [3:0] IDLE_FORCE_STAGE = 4'h6;
  localparam sdtx_code_t IDLE_SEQ [IDLE_STAGES] = '{
    10'h17c, 10'h289, 10'h283, 10'h289, 10'h17c, 10'h289, 10'h289, 10'h289,
    10'h17c, 10'h289, 10'h283, 10'h289, 10'h17c, 10'h289, 10'h283, 10'h289
  };

endpackage

//--- hw/sdtx_pat_if.sv
interface sdtx_pat_if;
  logic       enable;
  logic [9:0] force_code;
  logic [9:0] code;
  logic       active;
  modport gen (input enable, input force_code, output code, output active);
  modport ctl (output enable, output force_code, input code, input active);
endinterface

//--- hw/sdtx_idle_gen.sv
module sdtx_idle_gen
  import sdtx_pkg::*;
(
  input wire logic i_clk,   // core clock
  input wire logic i_reset, // sync reset, high
  input wire logic i_ce,    // clock enable
  sdtx_pat_if.gen  pat      // pattern control and output
);
  import sdtx_pkg::*;

  typedef struct packed {
    logic [3:0] stage;
    logic [9:0] code;
    logic       active;
  } sdtx_gen_st_t;

  sdtx_gen_st_t q, d;

  always_comb begin
    d = '0;
    if (pat.enable) begin
      d.active = 1'b1;
      // runs independent of link state; nothing here looks at the link
      d.code   = (q.stage == IDLE_FORCE_STAGE) ? pat.force_code : IDLE_SEQ[q.stage];
      d.stage  = q.stage + 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign pat.code   = q.code;
  assign pat.active = q.active;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset || !i_ce);

  AST_IDLE_STAGE6: assert property (pat.enable && q.stage == IDLE_FORCE_STAGE |=> q.code == $past(pat.force_code))
    else $error("stage six did not carry the force code");
  AST_IDLE_WRAP: assert property (pat.enable && q.stage == 4'hf |=> q.stage == 4'h0 && q.code == IDLE_SEQ[15])
    else $error("idle pattern did not wrap after sixteen stages");
  AST_IDLE_STOP: assert property (!pat.enable |=> !pat.active && q.stage == 4'h0)
    else $error("idle pattern kept running after disable");

endmodule

//--- hw/sdtx_regs.sv
// Behaviour
// - index 20h decodes to control-1 or drive register by the block-select register
// - with amplitude override set, drive bits 15:12 pick one of 16 amplitude steps
// - without override, amplitude bit 14 follows media mode; only 15,13,12 writable
// - writing 1 to link-test bit 14 restarts error counter bits 15:8 from zero, counting a bit error in that same cycle
// - link-test bit 13 starts the idle test pattern; clearing it stops it
// - idle pattern is 16 stages of 10-bit codes, sent regardless of link
// - force register bits 9:0 replace the stage-6 code group
// - link-test bit 5 lets packets go out with link down or unsynced
// - control-1 bit 0 chooses serial (0) or fiber (1); amplitude bit 14 follows it only without override
module sdtx_regs
  import sdtx_pkg::*;
#(
  parameter int ADR_W = 10
) (
  input  wire logic             i_clk,               // core clock
  input  wire logic             i_reset,             // sync reset, high
  input  wire logic             i_ce,                // clock enable, freezes state when low
  input  wire logic             i_wb_cyc,            // wishbone cycle
  input  wire logic             i_wb_stb,            // wishbone strobe
  input  wire logic             i_wb_we,             // wishbone write
  input  wire logic [ADR_W-1:0] i_wb_adr,            // wishbone byte address
  input  wire logic [3:0]       i_wb_sel,            // wishbone byte selects
  input  wire logic [31:0]      i_wb_dat,            // wishbone write data
  output logic      [31:0]      o_wb_dat,            // wishbone read data
  output logic                  o_wb_ack,            // wishbone ack
  input  wire logic             i_link_up,           // link established
  input  wire logic             i_sync_ok,           // receive sync achieved
  input  wire logic             i_ber_event,         // one bit-error event
  input  wire logic             i_crc_event,         // one crc-error event
  output logic      [3:0]       o_tx_amplitude,      // effective drive amplitude code
  output logic      [2:0]       o_emphasis_strength, // pre-emphasis code
  output logic                  o_fiber_mode,        // 1 fiber, 0 serial gigabit
  output logic                  o_tx_allowed,        // packet transmit gate
  output logic                  o_idle_test_active,  // idle pattern on the line
  output logic      [9:0]       o_idle_code,         // idle pattern code group
  output logic      [15:0]      o_error_count        // ber 15:8, crc 7:0
);
  import sdtx_pkg::*;

  typedef struct packed {
    logic        ack;
    logic [15:0] dat;
    logic        amp_ovr;
    logic        fiber;
    logic [3:0]  amp;
    logic [2:0]  emph;
    logic [5:0]  rsv_low;
    logic        clear_error_tally;
    logic        idle_test_pattern_enable;
    logic        force_send_ignore_link;
    logic [9:0]  force_code;
    logic [3:0]  blk_sel;
    logic [15:0] err;
  } sdtx_st_t;

  sdtx_st_t q, d;

  sdtx_pat_if pat ();

  function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [7:0] idx);
    hit = (adr == ADR_W'({idx, 2'b00}));
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wv, input logic [1:0] sel);
    merge = {sel[1] ? wv[15:8] : old[15:8], sel[0] ? wv[7:0] : old[7:0]};
  endfunction

  function automatic logic [7:0] tally(input logic [7:0] cur, input logic clr, input logic ev);
    logic [7:0] base;
    base = clr ? 8'h00 : cur;
    // an event in the clearing cycle is counted, never lost
    tally = (ev && base != 8'hff) ? base + 8'h01 : base;
  endfunction

  logic [3:0]  amp_eff;
  logic        req_new;
  logic        wr_now;
  logic [15:0] rd;
  logic [15:0] wv;

  // without override, the mode bit of the amplitude is tied to the media mode
  assign amp_eff = q.amp_ovr ? q.amp : {q.amp[3], q.fiber, q.amp[1:0]};
  assign req_new = i_wb_cyc && i_wb_stb && !q.ack;
  // writes land on the edge the master samples ack
  assign wr_now  = i_wb_cyc && i_wb_stb && i_wb_we && q.ack;

  always_comb begin
    rd = 16'h0000;
    if (hit(i_wb_adr, IDX_DRIVE)) begin
      unique case (q.blk_sel)
        BLK_CTRL1: begin
          rd[CTL1_OVR_BIT]   = q.amp_ovr;
          rd[CTL1_FIBER_BIT] = q.fiber;
        end
        BLK_DRIVE: rd = {amp_eff, DRV_RSV_MID, q.emph, q.rsv_low};
        default:   rd = 16'h0000;
      endcase
    end else if (hit(i_wb_adr, IDX_LINKTEST)) begin
      // reserved bits read zero; software must not rely on them
      // the clear acts on the write edge itself, so the bit never reads back set
      rd[LT_CLR_BIT]   = 1'b0;
      rd[LT_IDLE_BIT]  = q.idle_test_pattern_enable;
      rd[LT_FORCE_BIT] = q.force_send_ignore_link;
    end else if (hit(i_wb_adr, IDX_ERRCNT)) begin
      rd = q.err;
    end else if (hit(i_wb_adr, IDX_FORCE1)) begin
      rd = {6'h00, q.force_code};
    end else if (hit(i_wb_adr, IDX_BLKSEL)) begin
      rd = {12'h000, q.blk_sel};
    end
  end

  assign wv = merge(rd, i_wb_dat[15:0], i_wb_sel[1:0]);

  always_comb begin
    d                   = q;
    d.clear_error_tally = 1'b0;
    d.ack               = req_new;
    if (req_new) begin
      d.dat = rd;
    end
    if (wr_now) begin
      if (hit(i_wb_adr, IDX_DRIVE) && q.blk_sel == BLK_CTRL1) begin
        d.amp_ovr = wv[CTL1_OVR_BIT];
        d.fiber   = wv[CTL1_FIBER_BIT];
      end else if (hit(i_wb_adr, IDX_DRIVE) && q.blk_sel == BLK_DRIVE) begin
        d.amp[3] = wv[DRV_AMP_LSB+3];
        d.amp[1] = wv[DRV_AMP_LSB+1];
        d.amp[0] = wv[DRV_AMP_LSB];
        if (q.amp_ovr) begin
          d.amp[2] = wv[DRV_AMP_LSB+2];
        end
        d.emph    = wv[DRV_EMPH_LSB+2:DRV_EMPH_LSB];
        d.rsv_low = wv[5:0];
      end else if (hit(i_wb_adr, IDX_LINKTEST)) begin
        d.clear_error_tally        = wv[LT_CLR_BIT] && i_wb_sel[1];
        d.idle_test_pattern_enable = wv[LT_IDLE_BIT];
        d.force_send_ignore_link   = wv[LT_FORCE_BIT];
      end else if (hit(i_wb_adr, IDX_FORCE1)) begin
        d.force_code = wv[9:0];
      end else if (hit(i_wb_adr, IDX_BLKSEL)) begin
        d.blk_sel = wv[3:0];
      end
    end
    d.err[15:ERR_BER_LSB] = tally(q.err[15:ERR_BER_LSB], d.clear_error_tally, i_ber_event);
    d.err[ERR_BER_LSB-1:0] = tally(q.err[ERR_BER_LSB-1:0], 1'b0, i_crc_event);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q            <= '0;
      q.amp        <= DRV_AMP_RST;
      q.emph       <= DRV_EMPH_RST;
      q.rsv_low    <= DRV_RSV_LOW_RST;
      q.force_code <= FORCE1_RST;
      q.blk_sel    <= BLK_SEL_RST;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign pat.enable     = q.idle_test_pattern_enable;
  assign pat.force_code = q.force_code;

  sdtx_idle_gen u_idle (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .pat     (pat.gen)
  );

  assign o_wb_ack            = q.ack;
  assign o_wb_dat            = {16'h0000, q.dat};
  assign o_tx_amplitude      = amp_eff;
  assign o_emphasis_strength = q.emph;
  assign o_fiber_mode        = q.fiber;
  assign o_tx_allowed        = (i_link_up && i_sync_ok) || q.force_send_ignore_link;
  assign o_idle_test_active  = pat.active;
  assign o_idle_code         = pat.code;
  assign o_error_count       = q.err;

  // assertion helpers
  logic wr_drive;
  logic wr_lt;
  assign wr_drive = i_ce && wr_now && hit(i_wb_adr, IDX_DRIVE) && q.blk_sel == BLK_DRIVE && i_wb_sel[1:0] == 2'b11;
  assign wr_lt    = i_ce && wr_now && hit(i_wb_adr, IDX_LINKTEST) && i_wb_sel[1:0] == 2'b11;

  // helpers for the bus-side checks below
  logic rd_taken;
  logic rd_lt;
  logic rd_force;
  logic wr_any;
  logic wr_ctrl1;
  logic wr_force;
  logic wr_blksel;
  logic drive_unmapped;
  assign rd_taken       = i_ce && req_new && !i_wb_we;
  assign rd_lt          = rd_taken && hit(i_wb_adr, IDX_LINKTEST);
  assign rd_force       = rd_taken && hit(i_wb_adr, IDX_FORCE1);
  assign wr_any         = i_ce && wr_now;
  assign wr_ctrl1       = wr_any && hit(i_wb_adr, IDX_DRIVE) && q.blk_sel == BLK_CTRL1 && i_wb_sel[0];
  assign wr_force       = wr_any && hit(i_wb_adr, IDX_FORCE1) && i_wb_sel[1:0] == 2'b11;
  assign wr_blksel      = wr_any && hit(i_wb_adr, IDX_BLKSEL) && i_wb_sel[0];
  // the shared index decodes to nothing under any other block number
  assign drive_unmapped = hit(i_wb_adr, IDX_DRIVE) && q.blk_sel != BLK_CTRL1 && q.blk_sel != BLK_DRIVE;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset || !i_ce);

  AST_BLOCK_DECODE: assert property (
    i_ce && req_new && !i_wb_we && hit(i_wb_adr, IDX_DRIVE) && q.blk_sel == BLK_DRIVE
    |=> o_wb_ack && o_wb_dat[15:12] == $past(o_tx_amplitude) && o_wb_dat[11:9] == DRV_RSV_MID)
    else $error("drive register not decoded under block one");
  AST_BLOCK0_DECODE: assert property (
    i_ce && req_new && !i_wb_we && hit(i_wb_adr, IDX_DRIVE) && q.blk_sel == BLK_CTRL1
    |=> o_wb_dat[CTL1_FIBER_BIT] == $past(o_fiber_mode) && o_wb_dat[11:9] == 3'h0)
    else $error("control register not decoded under block zero");
  AST_AMP_OVERRIDE: assert property (wr_drive && q.amp_ovr |=> o_tx_amplitude == $past(i_wb_dat[15:12]))
    else $error("override amplitude not taken from write");
  AST_AMP_MODE: assert property (!q.amp_ovr |-> o_tx_amplitude[AMP_MODE_BIT] == o_fiber_mode)
    else $error("amplitude bit does not follow media mode");
  AST_EMPH: assert property (wr_drive |=> o_emphasis_strength == $past(i_wb_dat[8:6]))
    else $error("emphasis code not written");
  AST_BER_CLEAR: assert property (wr_lt && i_wb_dat[LT_CLR_BIT] && !i_ber_event |=> o_error_count[15:8] == 8'h00)
    else $error("bit error tally not cleared");
  AST_SELF_CLEAR: assert property (q.clear_error_tally |=> !q.clear_error_tally)
    else $error("counter clear bit did not self clear");
  AST_IDLE_START: assert property (wr_lt && i_wb_dat[LT_IDLE_BIT] |=> ##1 o_idle_test_active)
    else $error("idle pattern did not start");
  AST_FORCE_SEND: assert property (wr_lt && i_wb_dat[LT_FORCE_BIT] |=> o_tx_allowed)
    else $error("forced transmit not allowed");

  // bus answer: one acknowledge per request, one cycle wide
  AST_ACK_ANSWER: assert property (
    i_ce && req_new
    |=> o_wb_ack)
    else $error("request not acknowledged in the next cycle");
  AST_ACK_PULSE: assert property (
    o_wb_ack
    |=> !o_wb_ack)
    else $error("acknowledge stood longer than one cycle");

  // block numbers two and up leave the shared index unmapped
  AST_BLK_UNMAPPED_RD: assert property (
    rd_taken && drive_unmapped
    |=> o_wb_dat == 32'h0)
    else $error("unmapped block did not read zero");
  AST_BLK_UNMAPPED_WR: assert property (
    wr_any && drive_unmapped
    |=> $stable(o_tx_amplitude) && $stable(o_emphasis_strength) && $stable(o_fiber_mode))
    else $error("write to unmapped block changed a setting");
  AST_BLKSEL_WRITE: assert property (
    wr_blksel
    |=> q.blk_sel == $past(i_wb_dat[3:0]))
    else $error("block select not written");

  // amplitude: the mode bit is locked without override, the rest always writable
  AST_AMP_LOCKED: assert property (
    wr_drive && !q.amp_ovr
    |=> q.amp[AMP_MODE_BIT] == $past(q.amp[AMP_MODE_BIT]))
    else $error("locked amplitude bit took a write");
  AST_AMP_WRITABLE: assert property (
    wr_drive
    |=> o_tx_amplitude[3] == $past(i_wb_dat[15]) && o_tx_amplitude[1:0] == $past(i_wb_dat[13:12]))
    else $error("writable amplitude bits not taken");
  AST_FIBER_WRITE: assert property (
    wr_ctrl1
    |=> o_fiber_mode == $past(i_wb_dat[CTL1_FIBER_BIT]))
    else $error("media mode not written");

  // tallies: only the bit-error half clears, and an event in the clearing cycle still counts
  AST_BER_EVENT_WINS: assert property (
    wr_lt && i_wb_dat[LT_CLR_BIT] && i_ber_event
    |=> o_error_count[15:8] == 8'h01)
    else $error("bit error in the clearing cycle was lost");
  AST_CRC_KEPT: assert property (
    wr_lt && i_wb_dat[LT_CLR_BIT] && !i_crc_event
    |=> o_error_count[7:0] == $past(o_error_count[7:0]))
    else $error("crc tally disturbed by the bit error clear");
  AST_CRC_SATURATE: assert property (
    o_error_count[7:0] == 8'hff
    |=> o_error_count[7:0] == 8'hff)
    else $error("crc tally wrapped past its ceiling");

  // link-test register: reserved bits and the clear bit read zero
  AST_LT_RESERVED: assert property (
    rd_lt
    |=> (o_wb_dat[15:0] & ~((16'h0001 << LT_IDLE_BIT) | (16'h0001 << LT_FORCE_BIT))) == 16'h0000)
    else $error("link-test reserved or clear bit read nonzero");
  AST_TX_GATE: assert property (
    wr_lt && !i_wb_dat[LT_FORCE_BIT]
    |=> o_tx_allowed == (i_link_up && i_sync_ok))
    else $error("transmit gate not back to link state");

  // force code register and the idle pattern
  AST_FORCE_CODE_WRITE: assert property (
    wr_force
    |=> pat.force_code == $past(i_wb_dat[9:0]))
    else $error("force code not written");
  AST_FORCE_CODE_READ: assert property (
    rd_force
    |=> o_wb_dat[9:0] == $past(pat.force_code))
    else $error("force code read back wrong");
  AST_IDLE_LINK_FREE: assert property (
    o_idle_test_active && q.idle_test_pattern_enable
    |=> o_idle_test_active)
    else $error("idle pattern stopped while still enabled");
  AST_IDLE_OFF_CODE: assert property (
    !o_idle_test_active
    |-> o_idle_code == 10'h000)
    else $error("code group on the line while the pattern is off");

  COV_IDLE_RUN: cover property (o_idle_test_active [*8]);
  COV_BER_CLEAR: cover property (wr_lt && i_wb_dat[LT_CLR_BIT] && o_error_count[15:8] != 8'h00);
  COV_AMP_WRITE: cover property (wr_drive && q.amp_ovr);
  COV_UNMAPPED_BLOCK: cover property (rd_taken && drive_unmapped);
  COV_FORCED_LINK_DOWN: cover property (q.force_send_ignore_link && !i_link_up);

endmodule

//--- verification/sdtx_regs_tb_top.sv
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module sdtx_regs_tb_top;
  import sdtx_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clk = 1'b0, i_reset = 1'b1, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
  logic [9:0]  i_wb_adr = '0;
  logic [3:0]  i_wb_sel = '0;
  logic [31:0] i_wb_dat = '0, o_wb_dat;
  logic        i_link_up = 1'b0, i_sync_ok = 1'b0, i_ber_event = 1'b0, i_crc_event = 1'b0;
  logic        i_ce = 1'b1;
  logic        o_wb_ack, o_fiber_mode, o_tx_allowed, o_idle_test_active;
  logic [3:0]  o_tx_amplitude;
  logic [2:0]  o_emphasis_strength;
  logic [9:0]  o_idle_code;
  logic [15:0] o_error_count;
  logic [31:0] rd_exp[$], rd_msk[$];
  sdtx_code_t  cq[$];
  sdtx_code_t  e_code;
  logic [31:0] e_dat, e_msk;
  int          n_fail = 0, n_compared = 0, cycles = 0;
  logic [2:0]  emph;
  logic [9:0]  fcode;
  logic [7:0]  nb, nc;

  sdtx_regs #(.ADR_W(10)) dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_link_up(i_link_up),
    .i_sync_ok(i_sync_ok), .i_ber_event(i_ber_event), .i_crc_event(i_crc_event),
    .o_tx_amplitude(o_tx_amplitude), .o_emphasis_strength(o_emphasis_strength),
    .o_fiber_mode(o_fiber_mode), .o_tx_allowed(o_tx_allowed), .o_idle_test_active(o_idle_test_active),
    .o_idle_code(o_idle_code), .o_error_count(o_error_count));

  always #2.5 i_clk = ~i_clk;

  task automatic conclude();
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // generous ceiling; the sequence needs well under a thousand cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      conclude();
    end
  end

  // read results: oldest note is checked when a read is acknowledged
  always @(posedge i_clk) begin
    // pop once into locals: the macro names its arguments more than once
    if (o_wb_ack === 1'b1 && i_wb_we === 1'b0 && rd_exp.size() > 0) begin
      e_dat = rd_exp.pop_front();
      e_msk = rd_msk.pop_front();
      `CHK("read data", e_dat, o_wb_dat & e_msk)
    end
    if (o_idle_test_active === 1'b1 && cq.size() > 0) begin
      e_code = cq.pop_front();
      `CHK("idle code", e_code, o_idle_code)
    end
  end

  task automatic wb(input logic we, input logic [7:0] idx, input logic [15:0] d,
                    input logic [15:0] msk = 16'hffff);
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= {idx, 2'b00};
    i_wb_sel <= 4'h3;
    i_wb_dat <= we ? {16'h0, d} : 32'h0;
    if (!we) begin
      rd_exp.push_back({16'h0, d & msk});
      rd_msk.push_back({16'h0, msk});
    end
    do @(posedge i_clk); while (o_wb_ack !== 1'b1);
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask

  task automatic settle();
    @(posedge i_clk);
    #1;
  endtask

  initial begin
    void'($urandom(32'h89c9c62f));
    emph  = 3'($urandom());
    fcode = 10'($urandom());
    nb    = 8'($urandom_range(20, 1));
    nc    = 8'($urandom_range(20, 1));
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    settle();
    `CHK("amp at reset", 4'h8, o_tx_amplitude)
    wb(0, IDX_FORCE1, 16'h0289);
    wb(0, IDX_DRIVE, 16'h0000);
    wb(1, IDX_BLKSEL, 16'h0001);
    wb(0, IDX_DRIVE, 16'h0820, 16'h0fff);
    // amplitude 0001 without override: bit 14 keeps following the media mode
    wb(1, IDX_DRIVE, {4'h1, 3'b000, emph, 6'h20});
    settle();
    `CHK("amp serial", 4'h1, o_tx_amplitude)
    `CHK("emphasis", emph, o_emphasis_strength)
    wb(0, IDX_DRIVE, {7'h04, emph, 6'h20}, 16'h0fff);
    wb(1, IDX_BLKSEL, 16'h0000);
    wb(1, IDX_DRIVE, 16'h0001);
    settle();
    `CHK("fiber", 1'b1, o_fiber_mode)
    `CHK("amp fiber", 4'h5, o_tx_amplitude)
    wb(1, IDX_DRIVE, 16'h1001);
    wb(1, IDX_BLKSEL, 16'h0001);
    wb(1, IDX_DRIVE, {4'ha, 3'b000, 3'h7, 6'h20});
    settle();
    `CHK("amp override", 4'ha, o_tx_amplitude)
    `CHK("emphasis max", 3'h7, o_emphasis_strength)
    wb(1, IDX_BLKSEL, 16'h0002);
    wb(0, IDX_DRIVE, 16'h0000);
    wb(0, 8'hff, 16'h0000);
    // error tallies, then clear only the bit-error half
    for (int i = 0; i < 20; i++) begin
      @(posedge i_clk);
      i_ber_event <= (i < nb);
      i_crc_event <= (i < nc);
    end
    @(posedge i_clk);
    i_ber_event <= 1'b0;
    i_crc_event <= 1'b0;
    wb(0, IDX_ERRCNT, {nb, nc});
    // clock enable low: events that arrive while frozen must not count
    @(posedge i_clk);
    i_ce        <= 1'b0;
    i_ber_event <= 1'b1;
    i_crc_event <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_ce        <= 1'b1;
    i_ber_event <= 1'b0;
    i_crc_event <= 1'b0;
    settle();
    `CHK("error count", {nb, nc}, o_error_count)
    `CHK("tx gate down", 1'b0, o_tx_allowed)
    wb(1, IDX_LINKTEST, 16'h4020);
    settle();
    `CHK("tx gate forced", 1'b1, o_tx_allowed)
    wb(0, IDX_ERRCNT, {8'h00, nc});
    settle();
    `CHK("error count cleared", {8'h00, nc}, o_error_count)
    wb(0, IDX_LINKTEST, 16'h0020);
    wb(1, IDX_LINKTEST, 16'h0000);
    i_link_up <= 1'b1;
    i_sync_ok <= 1'b1;
    settle();
    `CHK("tx gate link", 1'b1, o_tx_allowed)
    @(posedge i_clk);
    i_link_up <= 1'b0;
    // idle pattern with link down and a replaced stage 6
    wb(1, IDX_FORCE1, {6'h0, fcode});
    for (int i = 0; i < 20; i++) cq.push_back((i % 16 == 6) ? fcode : IDLE_SEQ[i % 16]);
    wb(1, IDX_LINKTEST, 16'h2000);
    repeat (25) settle();
    `CHK("codes left", 0, cq.size())
    wb(1, IDX_LINKTEST, 16'h0000);
    repeat (2) settle();
    `CHK("idle stopped", 1'b0, o_idle_test_active)
    `CHK("idle code off", 10'h000, o_idle_code)
    settle();
    `CHK("reads done", 0, rd_exp.size())
    conclude();
  end
endmodule
